// [core/pskc_pkg.sv]
// Constants, register layouts and bus carriers for the shutdown and key configuration bank
package pskc_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W  = 8;
   localparam int MS_W   = 14;

   // Register indices; byte address is index shifted left by BYTE_SHIFT
   localparam logic [ADDR_W-1:0] IDX_MERGE  = 12'h10d;
   localparam logic [ADDR_W-1:0] IDX_SHUT   = 12'h10e;
   localparam logic [ADDR_W-1:0] IDX_TIMING = 12'h10f;
   localparam logic [ADDR_W-1:0] IDX_CTRL   = 12'h120;
   localparam int BYTE_SHIFT = 2;

   localparam logic [REG_W-1:0] RST_MERGE  = 8'h00;
   localparam logic [REG_W-1:0] RST_SHUT   = 8'h00;
   localparam logic [REG_W-1:0] RST_TIMING = 8'h00;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Control/status register bits
   localparam int CTRL_HOST_SD = 0;
   localparam int STAT_RESET   = 0;
   localparam int STAT_POR     = 1;
   localparam int STAT_LOCK    = 2;
   localparam int STAT_IFRST   = 3;

   localparam logic [1:0] KEY_MODE_PORT = 2'h0;
   localparam logic [1:0] KEY_MODE_LOCK = 2'h1;

   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_NS         = 1000000;
   localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   localparam logic [MS_W-1:0] LIMIT_MS = 14'd200;
   localparam logic [MS_W-1:0] TWI_MS   = 14'd19;
   localparam logic [MS_W-1:0] RST_MS_0 = 14'd20;
   localparam logic [MS_W-1:0] RST_MS_1 = 14'd100;
   localparam logic [MS_W-1:0] RST_MS_2 = 14'd500;
   localparam logic [MS_W-1:0] RST_MS_3 = 14'd1000;
   localparam logic [MS_W-1:0] SHUT_MS_0 = 14'd0;
   localparam logic [MS_W-1:0] SHUT_MS_1 = 14'd4000;
   localparam logic [MS_W-1:0] SHUT_MS_2 = 14'd5000;
   localparam logic [MS_W-1:0] SHUT_MS_3 = 14'd6000;
   localparam logic [MS_W-1:0] KEY_MS_0 = 14'd1000;
   localparam logic [MS_W-1:0] KEY_MS_1 = 14'd1500;
   localparam logic [MS_W-1:0] KEY_MS_2 = 14'd2000;
   localparam logic [MS_W-1:0] KEY_MS_3 = 14'd7000;

   typedef struct packed {
      logic mem_io_merge;
      logic core1_overdrive;
      logic core2_overdrive;
      logic proc_conv_overdrive;
      logic core_dual_phase;
      logic merged_sense_route;
      logic motor_driver_select;
      logic pwm_clk_slow;
   } pskc_merge_t;

   typedef struct packed {
      logic       regulator_limit_shutdown;
      logic       fault_shutdown_speed;
      logic       host_shutdown_speed;
      logic       user_shutdown_speed;
      logic       dual_input_shutdown_en;
      logic       long_press_shutdown_en;
      logic [1:0] power_key_pin_mode;
   } pskc_shut_t;

   typedef struct packed {
      logic       if_reset_en;
      logic       two_wire_timeout_en;
      logic [1:0] reset_duration;
      logic [1:0] shut_delay;
      logic [1:0] key_delay;
   } pskc_timing_t;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } pskc_axi_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } pskc_axi_rsp_t;

   typedef enum {ST_ACTIVE, ST_POR, ST_HOLD} pskc_state_t;
endpackage

// [core/pskc_top.sv]
// Shutdown, power key and converter configuration bank with AXI4-Lite access
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

module pskc_top
#(
   parameter int MS_CYCLES = pskc_pkg::MS_CYCLES
)
(
   input  wire logic                    mclk,
   input  wire logic                    rst_b,
   input  wire pskc_pkg::pskc_axi_req_t axi_req,
   output pskc_pkg::pskc_axi_rsp_t      axi_rsp,
   input  wire logic                    power_key_pin_b,
   input  wire logic                    gpi14,
   input  wire logic                    gpi15,
   input  wire logic                    shutdown_pin_b,
   input  wire logic                    fault_event,
   input  wire logic                    remote_sense_en,
   input  wire logic [4:0]              reg_in_limit,
   input  wire logic                    twi_scl,
   output logic                         io_ctrl_en_q,
   output logic                         core2_ctrl_en_q,
   output logic [2:0]                   overdrive_q,
   output logic                         sense_to_fb2_q,
   output logic                         sense_to_sw_q,
   output logic                         motor_mode_q,
   output logic                         pwm_clk_slow_q,
   output logic [4:0]                   reg_off_q,
   output logic                         sd_start_q,
   output logic                         sd_fast_q,
   output logic                         por_q,
   output logic                         reset_mode_q,
   output logic                         powerup_q,
   output logic                         power_key_lock_q,
   output logic [1:0]                   key_mode_q,
   output logic                         if_reset_q,
   output logic                         twi_reset_q
);
   import pskc_pkg::*;

   localparam int PRE_W = $clog2(MS_CYCLES);

   // Bus state
   logic              awready_q;
   logic              wready_q;
   logic              bvalid_q;
   logic [1:0]        bresp_q;
   logic              arready_q;
   logic              rvalid_q;
   logic [DATA_W-1:0] rdata_q;
   logic [1:0]        rresp_q;
   logic              aw_got_q;
   logic              w_got_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [REG_W-1:0]  wdata_q;
   logic              wstrb_q;

   pskc_merge_t  merge_q;
   pskc_shut_t   shut_q;
   pskc_timing_t timing_q;
   logic         host_sd_req_q;

   logic [PRE_W-1:0] pre_q;
   logic             tick_q;
   pskc_state_t      state_q;
   logic [MS_W-1:0]  hold_q;
   logic             scl_q;
   logic [MS_W-1:0]  twi_ms_q;
   logic [MS_W-1:0]  press_q [2];

   assign axi_rsp.awready = awready_q;
   assign axi_rsp.wready  = wready_q;
   assign axi_rsp.bvalid  = bvalid_q;
   assign axi_rsp.bresp   = bresp_q;
   assign axi_rsp.arready = arready_q;
   assign axi_rsp.rvalid  = rvalid_q;
   assign axi_rsp.rdata   = rdata_q;
   assign axi_rsp.rresp   = rresp_q;

   // Address decode
   wire [ADDR_W-1:0] ar_idx = {2'h0, axi_req.araddr[ADDR_W-1:BYTE_SHIFT]};
   wire [ADDR_W-1:0] aw_idx = {2'h0, awaddr_q[ADDR_W-1:BYTE_SHIFT]};
   wire rd_merge  = ar_idx == IDX_MERGE;
   wire rd_shut   = ar_idx == IDX_SHUT;
   wire rd_timing = ar_idx == IDX_TIMING;
   wire rd_ctrl   = ar_idx == IDX_CTRL;
   wire rd_hit    = rd_merge | rd_shut | rd_timing | rd_ctrl;
   wire wr_merge  = aw_idx == IDX_MERGE;
   wire wr_shut   = aw_idx == IDX_SHUT;
   wire wr_timing = aw_idx == IDX_TIMING;
   wire wr_ctrl   = aw_idx == IDX_CTRL;
   wire wr_hit    = wr_merge | wr_shut | wr_timing | wr_ctrl;
   wire wr_fire   = aw_got_q & w_got_q & ~bvalid_q;
   wire wr_en     = wr_fire & wstrb_q;

   wire [REG_W-1:0] status = {4'h0, if_reset_q, power_key_lock_q, por_q, reset_mode_q};
   wire [REG_W-1:0] rd_byte = rd_merge  ? REG_W'(merge_q) :
                              rd_shut   ? REG_W'(shut_q) :
                              rd_timing ? REG_W'(timing_q) :
                              rd_ctrl   ? status : 8'h00;

   // Write address/data channels taken in either order; response after both
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         aw_got_q  <= 1'b0;
         w_got_q   <= 1'b0;
         awaddr_q  <= '0;
         wdata_q   <= '0;
         wstrb_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end
      else
      begin
         if (axi_req.awvalid && awready_q)
         begin
            awaddr_q  <= axi_req.awaddr;
            aw_got_q  <= 1'b1;
            awready_q <= 1'b0;
         end
         if (axi_req.wvalid && wready_q)
         begin
            wdata_q  <= axi_req.wdata[REG_W-1:0];
            wstrb_q  <= axi_req.wstrb[0];
            w_got_q  <= 1'b1;
            wready_q <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_q && axi_req.bready)
         begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= '0;
         rresp_q   <= RESP_OKAY;
      end
      else if (axi_req.arvalid && arready_q)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
         rresp_q   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_q && axi_req.rready)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         merge_q       <= pskc_merge_t'(RST_MERGE);
         shut_q        <= pskc_shut_t'(RST_SHUT);
         timing_q      <= pskc_timing_t'(RST_TIMING);
         host_sd_req_q <= 1'b0;
      end
      else
      begin
         if (wr_en && wr_merge)
            merge_q <= pskc_merge_t'(wdata_q);
         if (wr_en && wr_shut)
            shut_q <= pskc_shut_t'(wdata_q);
         if (wr_en && wr_timing)
            timing_q <= pskc_timing_t'(wdata_q);
         host_sd_req_q <= wr_en & wr_ctrl & wdata_q[CTRL_HOST_SD];
      end
   end

   // Converter steering and power key pin mode outputs
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         io_ctrl_en_q    <= 1'b1;
         core2_ctrl_en_q <= 1'b1;
         overdrive_q     <= '0;
         sense_to_fb2_q  <= 1'b0;
         sense_to_sw_q   <= 1'b0;
         motor_mode_q    <= 1'b0;
         pwm_clk_slow_q  <= 1'b0;
         key_mode_q      <= KEY_MODE_PORT;
      end
      else
      begin
         io_ctrl_en_q    <= ~merge_q.mem_io_merge;
         core2_ctrl_en_q <= ~merge_q.core_dual_phase;
         overdrive_q     <= {merge_q.core1_overdrive, merge_q.core2_overdrive,
                             merge_q.proc_conv_overdrive};
         sense_to_fb2_q  <= merge_q.core_dual_phase & remote_sense_en
                            & ~merge_q.merged_sense_route;
         sense_to_sw_q   <= merge_q.core_dual_phase & remote_sense_en
                            & merge_q.merged_sense_route;
         motor_mode_q    <= merge_q.motor_driver_select;
         pwm_clk_slow_q  <= merge_q.pwm_clk_slow;
         key_mode_q      <= shut_q.power_key_pin_mode;
      end
   end

   // Millisecond time base
   wire pre_wrap = pre_q == PRE_W'(MS_CYCLES - 1);

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pre_q  <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         pre_q  <= pre_wrap ? '0 : pre_q + 1'b1;
         tick_q <= pre_wrap;
      end
   end

   // Threshold selection
   wire [MS_W-1:0] key_ms = (timing_q.key_delay == 2'h0) ? KEY_MS_0 :
                            (timing_q.key_delay == 2'h1) ? KEY_MS_1 :
                            (timing_q.key_delay == 2'h2) ? KEY_MS_2 : KEY_MS_3;
   wire [MS_W-1:0] add_ms = (timing_q.shut_delay == 2'h0) ? SHUT_MS_0 :
                            (timing_q.shut_delay == 2'h1) ? SHUT_MS_1 :
                            (timing_q.shut_delay == 2'h2) ? SHUT_MS_2 : SHUT_MS_3;
   wire [MS_W-1:0] long_ms = key_ms + add_ms;
   wire [MS_W-1:0] rst_ms = (timing_q.reset_duration == 2'h0) ? RST_MS_0 :
                            (timing_q.reset_duration == 2'h1) ? RST_MS_1 :
                            (timing_q.reset_duration == 2'h2) ? RST_MS_2 : RST_MS_3;

   // Press timers: index 0 power key, index 1 GPIO 14 and 15 together
   wire key_mode = shut_q.power_key_pin_mode != KEY_MODE_PORT;
   wire [1:0] press_act = {gpi14 & gpi15, key_mode & ~power_key_pin_b};
   wire [1:0] press_long;

   for (genvar i = 0; i < 2; i++)
   begin : g_press
      always_ff @(posedge mclk or negedge rst_b)
      begin
         if (!rst_b)
            press_q[i] <= '0;
         else if (!press_act[i])
            press_q[i] <= '0;
         else if (tick_q && press_q[i] != {MS_W{1'b1}})
            press_q[i] <= press_q[i] + 1'b1;
      end
      assign press_long[i] = press_act[i] && press_q[i] > long_ms;
   end

   // Autonomous long-press shutdown only in the two autonomous key modes
   wire key_auto = key_mode && shut_q.power_key_pin_mode != KEY_MODE_LOCK;
   wire user_sd = (shut_q.long_press_shutdown_en & key_auto & press_long[0])
                | (shut_q.dual_input_shutdown_en & press_long[1]);
   wire host_sd = ~shutdown_pin_b | host_sd_req_q;

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         power_key_lock_q <= 1'b0;
      else
         power_key_lock_q <= press_act[0] && press_q[0] > key_ms;
   end

   // Power controller sequence
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q      <= ST_ACTIVE;
         hold_q       <= '0;
         sd_start_q   <= 1'b0;
         sd_fast_q    <= 1'b0;
         por_q        <= 1'b0;
         reset_mode_q <= 1'b0;
         powerup_q    <= 1'b0;
      end
      else
      begin
         sd_start_q <= 1'b0;
         powerup_q  <= 1'b0;
         case (state_q)
            ST_ACTIVE:
               if (fault_event || host_sd || user_sd)
               begin
                  sd_start_q   <= 1'b1;
                  reset_mode_q <= 1'b1;
                  hold_q       <= '0;
                  if (fault_event)
                     sd_fast_q <= shut_q.fault_shutdown_speed;
                  else if (host_sd)
                     sd_fast_q <= shut_q.host_shutdown_speed;
                  else
                     sd_fast_q <= 1'b0;
                  if (!fault_event && !host_sd && shut_q.user_shutdown_speed)
                  begin
                     state_q <= ST_POR;
                     por_q   <= 1'b1;
                  end
                  else
                     state_q <= ST_HOLD;
               end
            ST_POR:
               if (tick_q)
               begin
                  state_q <= ST_HOLD;
                  por_q   <= 1'b0;
               end
            ST_HOLD:
               if (tick_q)
               begin
                  if (hold_q > rst_ms)
                  begin
                     state_q      <= ST_ACTIVE;
                     reset_mode_q <= 1'b0;
                     powerup_q    <= 1'b1;
                  end
                  else
                     hold_q <= hold_q + 1'b1;
               end
            default:
               state_q <= ST_ACTIVE;
         endcase
      end
   end

   // Regulator current-limit shutdown
   for (genvar r = 0; r < 5; r++)
   begin : g_limit
      logic [MS_W-1:0] lim_q;

      always_ff @(posedge mclk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            lim_q        <= '0;
            reg_off_q[r] <= 1'b0;
         end
         else
         begin
            if (!reg_in_limit[r])
               lim_q <= '0;
            else if (tick_q && lim_q != {MS_W{1'b1}})
               lim_q <= lim_q + 1'b1;
            if (powerup_q)
               reg_off_q[r] <= 1'b0;
            else if (shut_q.regulator_limit_shutdown && lim_q > LIMIT_MS)
               reg_off_q[r] <= 1'b1;
         end
      end
   end

   // Interface resets
   wire scl_edge = twi_scl != scl_q;

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         scl_q       <= 1'b0;
         twi_ms_q    <= '0;
         twi_reset_q <= 1'b0;
         if_reset_q  <= 1'b0;
      end
      else
      begin
         scl_q       <= twi_scl;
         if_reset_q  <= timing_q.if_reset_en & ~shutdown_pin_b;
         twi_reset_q <= 1'b0;
         if (scl_edge || !timing_q.two_wire_timeout_en)
            twi_ms_q <= '0;
         else if (twi_ms_q > TWI_MS)
         begin
            twi_reset_q <= 1'b1;
            twi_ms_q    <= '0;
         end
         else if (tick_q)
            twi_ms_q <= twi_ms_q + 1'b1;
      end
   end
endmodule

// [bench/pskc_properties.sv]
// Port-level timing checks for the shutdown and key configuration bank
`timescale 1ns/1ns
module pskc_checker
#(
   parameter int MS_CYCLES = 4
)
(
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic       power_key_pin_b,
   input wire logic       shutdown_pin_b,
   input wire logic [4:0] reg_in_limit,
   input wire logic       twi_scl,
   input wire logic [4:0] reg_off_q,
   input wire logic       sd_start_q,
   input wire logic       por_q,
   input wire logic       reset_mode_q,
   input wire logic       powerup_q,
   input wire logic       power_key_lock_q,
   input wire logic       if_reset_q,
   input wire logic       twi_reset_q
);
   int   rm_n;
   int   idle_n;
   int   key_n;
   int   lim_n;
   logic scl_q;

   // Cycle counts of reset mode, idle clock, key press and current limit
   always_ff @(posedge mclk or negedge rst_b)
      if (!rst_b)
      begin
         rm_n   <= 0;
         idle_n <= 0;
         key_n  <= 0;
         lim_n  <= 0;
         scl_q  <= 1'b0;
      end
      else
      begin
         rm_n   <= reset_mode_q ? rm_n + 1 : 0;
         idle_n <= (twi_scl != scl_q) ? 0 : idle_n + 1;
         key_n  <= power_key_pin_b ? 0 : key_n + 1;
         lim_n  <= reg_in_limit[0] ? lim_n + 1 : 0;
         scl_q  <= twi_scl;
      end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sd_pulse_a: assert property (sd_start_q |=> !sd_start_q)
      else $error("shutdown start held longer than one cycle");
   sd_enters_reset_a: assert property (sd_start_q |=> reset_mode_q)
      else $error("shutdown start without reset mode");
   por_in_reset_a: assert property (por_q |-> reset_mode_q)
      else $error("forced power-on reset outside reset mode");
   powerup_after_a: assert property (powerup_q |-> !reset_mode_q && !por_q)
      else $error("power-up allowed while still in reset");
   reset_min_a: assert property ($fell(reset_mode_q) |-> rm_n >= 20 * MS_CYCLES - 1)
      else $error("reset mode shorter than minimum duration");
   twi_idle_a: assert property (twi_reset_q |-> idle_n >= 19 * MS_CYCLES - 2)
      else $error("two-wire reset before clock idle time");
   twi_pulse_a: assert property (twi_reset_q |=> !twi_reset_q)
      else $error("two-wire reset longer than one cycle");
   lock_delay_a: assert property ($rose(power_key_lock_q) |-> key_n >= 999 * MS_CYCLES)
      else $error("key lock before shortest key delay");
   lock_release_a: assert property (power_key_pin_b [*3] |-> !power_key_lock_q)
      else $error("key lock kept after key release");
   limit_time_a: assert property ($rose(reg_off_q[0]) |-> lim_n >= 199 * MS_CYCLES)
      else $error("regulator shut down before limit time");
   ifrst_release_a: assert property (shutdown_pin_b [*3] |-> !if_reset_q)
      else $error("interface reset without shutdown pin");

   cover property ($rose(por_q));
   cover property (twi_reset_q);
   cover property ($rose(power_key_lock_q));
endmodule

bind pskc_top pskc_checker #(.MS_CYCLES(MS_CYCLES)) pskc_checker_i (.mclk, .rst_b, .power_key_pin_b,
   .shutdown_pin_b, .reg_in_limit, .twi_scl, .reg_off_q, .sd_start_q, .por_q, .reset_mode_q, .powerup_q,
   .power_key_lock_q, .if_reset_q, .twi_reset_q);

// [bench/pskc_host_model.sv]
// Host and power key stand-in driving the user-side pins
`timescale 1ns/1ns
module pskc_host_model
(
   input  wire logic mclk,
   input  wire logic key_hold,
   input  wire logic dual_hold,
   input  wire logic host_sd,
   input  wire logic scl_run,
   output logic      power_key_pin_b,
   output logic      gpi14,
   output logic      gpi15,
   output logic      shutdown_pin_b,
   output logic      twi_scl
);
   initial
   begin
      {gpi14, gpi15, twi_scl} = 3'h0;
      {power_key_pin_b, shutdown_pin_b} = 2'h3;
   end

   always @(posedge mclk)
   begin
      power_key_pin_b <= !key_hold;
      gpi14 <= dual_hold;
      gpi15 <= dual_hold;
      shutdown_pin_b <= !host_sd;
      if (scl_run)
         twi_scl <= !twi_scl;
   end
endmodule

// [bench/tb_top.sv]
// Self-checking bench for the shutdown and key configuration bank
`timescale 1ns/1ns
module tb_top;
   import pskc_pkg::*;
   localparam int M = 4;
   logic mclk, rst_b, fault_event, remote_sense_en, key_hold, dual_hold, host_sd, scl_run;
   logic power_key_pin_b, gpi14, gpi15, shutdown_pin_b, twi_scl, sd_fast_q, if_reset_q;
   logic io_ctrl_en_q, core2_ctrl_en_q, sense_to_fb2_q, sense_to_sw_q, motor_mode_q, pwm_clk_slow_q;
   logic sd_start_q, por_q, reset_mode_q, powerup_q, power_key_lock_q, twi_reset_q;
   logic [4:0]    reg_in_limit, reg_off_q;
   logic [2:0]    overdrive_q;
   logic [1:0]    key_mode_q;
   logic [8:0]    outs;
   logic [5:0]    ev;
   logic [7:0]    v;
   pskc_axi_req_t req;
   pskc_axi_rsp_t rsp;
   int            num_errors = 0;
   int            comparisons = 0;
   int            durs [4] = '{20, 100, 500, 1000};
   logic [7:0]    mv [3] = '{8'hb5, 8'h4a, 8'h0c};

   assign outs = {io_ctrl_en_q, core2_ctrl_en_q, overdrive_q, sense_to_fb2_q, sense_to_sw_q, motor_mode_q, pwm_clk_slow_q};
   assign ev = {twi_reset_q, powerup_q, por_q, sd_start_q, power_key_lock_q, reg_off_q[0]};

   pskc_top #(.MS_CYCLES(M)) pskc_top_i (.mclk, .rst_b, .axi_req(req), .axi_rsp(rsp), .power_key_pin_b, .gpi14,
      .gpi15, .shutdown_pin_b, .fault_event, .remote_sense_en, .reg_in_limit, .twi_scl, .io_ctrl_en_q,
      .core2_ctrl_en_q, .overdrive_q, .sense_to_fb2_q, .sense_to_sw_q, .motor_mode_q, .pwm_clk_slow_q,
      .reg_off_q, .sd_start_q, .sd_fast_q, .por_q, .reset_mode_q, .powerup_q, .power_key_lock_q, .key_mode_q,
      .if_reset_q, .twi_reset_q);
   pskc_host_model pskc_host_model_i (.mclk, .key_hold, .dual_hold, .host_sd, .scl_run, .power_key_pin_b,
      .gpi14, .gpi15, .shutdown_pin_b, .twi_scl);

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task automatic end_sim;
      if (num_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h got %h", nm, exp, got);
      end
   endtask

   // Counts edges until the selected event shows, then checks the count
   task automatic wait_ev(input int k, input int lo, input int hi);
      int n;
      n = 0;
      while (ev[k] !== 1'b1 && n <= hi)
      begin
         @(posedge mclk);
         n++;
      end
      chk("event cycles", (n >= lo && n <= hi) ? n : -1, n);
   endtask

   task automatic axi_wr(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] r);
      int n;
      @(posedge mclk);
      req.awvalid <= 1'b1;
      req.awaddr <= {idx[9:0], 2'b00};
      req.wvalid <= 1'b1;
      req.wdata <= {24'h0, d};
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
         if (rsp.awready)
            req.awvalid <= 1'b0;
         if (rsp.wready)
            req.wvalid <= 1'b0;
      end
      while (rsp.bvalid !== 1'b1 && n < 100);
      req.bready <= 1'b0;
      chk("bresp", rsp.bresp, r);
   endtask

   task automatic axi_rd(input logic [11:0] idx, input logic [7:0] d, input logic [1:0] r);
      int n;
      @(posedge mclk);
      req.arvalid <= 1'b1;
      req.araddr <= {idx[9:0], 2'b00};
      req.rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
         if (rsp.arready)
            req.arvalid <= 1'b0;
      end
      while (rsp.rvalid !== 1'b1 && n < 100);
      req.rready <= 1'b0;
      chk("rdata", rsp.rdata, {24'h0, d});
      chk("rresp", rsp.rresp, r);
   endtask

   initial
   begin
      repeat (60000) @(posedge mclk);
      num_errors++;
      end_sim;
   end

   initial
   begin
      {rst_b, fault_event, key_hold, dual_hold, host_sd, reg_in_limit} = '0;
      {remote_sense_en, scl_run} = 2'h3;
      req = '0;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      chk("reset outs", outs, 9'h180);
      for (int i = 0; i < 3; i++)
         axi_rd(IDX_MERGE + 12'(i), 8'h00, RESP_OKAY);
      axi_rd(12'h111, 8'h00, RESP_SLVERR);
      axi_wr(12'h111, 8'hff, RESP_SLVERR);
      foreach (mv[i])
      begin
         v = mv[i];
         axi_wr(IDX_MERGE, v, RESP_OKAY);
         axi_rd(IDX_MERGE, v, RESP_OKAY);
         chk("merge", outs, {~v[7], ~v[3], v[6:4], v[3] & ~v[2], v[3] & v[2], v[1:0]});
      end
      // Overdrive, sense routing and motor mode are in the same compare above
      axi_wr(IDX_SHUT, 8'h80, RESP_OKAY);
      reg_in_limit <= 5'h01;
      wait_ev(0, 199 * M, 202 * M + 4);
      reg_in_limit <= 5'h00;
      axi_wr(IDX_TIMING, 8'h40, RESP_OKAY);
      scl_run <= 1'b0;
      wait_ev(5, 18 * M, 21 * M + 4);
      scl_run <= 1'b1;
      for (int k = 0; k < 4; k++)
      begin
         axi_wr(IDX_TIMING, {2'b10, 2'(k), 4'h0}, RESP_OKAY);
         axi_wr(IDX_SHUT, 8'h40 >> k, RESP_OKAY);
         host_sd <= k[0];
         fault_event <= !k[0];
         wait_ev(2, 1, 6);
         chk("sd_fast", sd_fast_q, k < 2);
         chk("if_reset", if_reset_q, k[0]);
         host_sd <= 1'b0;
         fault_event <= 1'b0;
         wait_ev(4, durs[k] * M, (durs[k] + 3) * M);
      end
      chk("reg_off", reg_off_q, 5'h00);
      axi_wr(IDX_TIMING, 8'h00, RESP_OKAY);
      axi_wr(IDX_SHUT, 8'h16, RESP_OKAY);
      key_hold <= 1'b1;
      wait_ev(1, 999 * M, 1002 * M + 6);
      chk("key_mode", key_mode_q, 2'h2);
      wait_ev(3, 0, 2 * M + 4);
      key_hold <= 1'b0;
      wait_ev(4, 20 * M, 24 * M + 4);
      axi_wr(IDX_TIMING, 8'h04, RESP_OKAY);
      axi_wr(IDX_SHUT, 8'h08, RESP_OKAY);
      dual_hold <= 1'b1;
      wait_ev(2, 4999 * M, 5002 * M + 6);
      chk("por", por_q, 1'b0);
      dual_hold <= 1'b0;
      wait_ev(4, 20 * M, 23 * M + 4);
      // Host shutdown through the control register, then status readback
      axi_wr(IDX_CTRL, 8'h01, RESP_OKAY);
      wait_ev(2, 1, 6);
      chk("sd_fast host", sd_fast_q, 1'b0);
      axi_rd(IDX_CTRL, 8'h01, RESP_OKAY);
      wait_ev(4, 18 * M, 23 * M + 4);
      end_sim;
   end
endmodule
